//--- rtl/arc_pkg.sv
package arc_pkg;
  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------
  localparam int CH_NUM = 16;
  localparam int LANE_LSB = 0;
  localparam int LANE_MSB = 1;
  localparam int IDX_LSB = 2;
  localparam int IDX_MSB = 3;
  localparam int DIR_BIT = 4;
  localparam int CH_LSB = 5;
  localparam int CH_MSB = 8;

  localparam logic [1:0] REG_DATA = 2'h0;
  localparam logic [1:0] REG_CTRL = 2'h1;
  localparam logic [1:0] REG_STAT = 2'h2;
  localparam logic [1:0] REG_LABEL = 2'h3;

  // ------------------------------------------------------------
  // Control fields
  // ------------------------------------------------------------
  localparam int CTL_RATE = 0;
  localparam int CTL_FILTER = 1;
  localparam int CTL_LOOP = 1;
  localparam int CTL_PAR_EN = 2;
  localparam int CTL_PAR_EVEN = 3;
  localparam int CTL_SDI_EN = 4;
  localparam int CTL_SDI9 = 5;
  localparam int CTL_SDI10 = 6;
  localparam int CTL_RELOAD = 7;
  localparam int RX_CTL_W = 8;
  localparam int TX_CTL_W = 4;
  localparam logic [RX_CTL_W-1:0] RX_CTL_RST = 8'h00;
  localparam logic [TX_CTL_W-1:0] TX_CTL_RST = 4'h0;

  // Status fields
  localparam int ST_EMPTY = 0;
  localparam int ST_LEVEL = 1;
  localparam int ST_FULL = 2;

  // ARINC word fields
  localparam int LBL_LSB = 0;
  localparam int LBL_W = 8;
  localparam int SDI9_POS = 8;
  localparam int SDI10_POS = 9;

  // ------------------------------------------------------------
  // Label memory and timing
  // ------------------------------------------------------------
  localparam int LABEL_DEPTH = 16;
  localparam int LABEL_AW = 4;
  localparam logic [2:0] LAT_CTRL_RD = 3'h1;
  localparam logic [2:0] LAT_DATA_RD = 3'h6;
  localparam logic [2:0] LAT_WR = 3'h2;
  localparam logic [2:0] CNT_ONE = 3'h1;

  typedef enum logic [1:0] {ARC_IDLE, ARC_BUSY, ARC_DONE} arc_state_t;
endpackage

//--- rtl/arc_label_mem.sv
`timescale 1ns/1ps
module arc_label_mem (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic clear,
  input wire logic wr_en,
  input wire logic [arc_pkg::LBL_W-1:0] wr_label,
  input wire logic rd_adv,
  output logic [arc_pkg::LBL_W-1:0] rd_label,
  input wire logic [arc_pkg::LBL_W-1:0] cand_label,
  output logic cand_hit
);
  logic [arc_pkg::LBL_W-1:0] mem_r [arc_pkg::LABEL_DEPTH];
  logic [arc_pkg::LBL_W-1:0] mem_nxt [arc_pkg::LABEL_DEPTH];
  logic [arc_pkg::LABEL_AW:0] wr_ptr_r, wr_ptr_nxt;
  logic [arc_pkg::LABEL_AW-1:0] rd_ptr_r, rd_ptr_nxt;
  localparam logic [arc_pkg::LABEL_AW:0] FULL_CNT = (arc_pkg::LABEL_AW+1)'(arc_pkg::LABEL_DEPTH);

  // ------------------------------------------------------------
  // Pointers and storage
  // ------------------------------------------------------------
  always_comb begin
    mem_nxt = mem_r;
    wr_ptr_nxt = wr_ptr_r;
    rd_ptr_nxt = rd_ptr_r;
    if (clear) begin
      wr_ptr_nxt = '0;
      rd_ptr_nxt = '0;
    end else begin
      if (wr_en && wr_ptr_r != FULL_CNT) begin
        mem_nxt[wr_ptr_r[arc_pkg::LABEL_AW-1:0]] = wr_label;
        wr_ptr_nxt = wr_ptr_r + 1'b1;
      end
      if (rd_adv) begin
        rd_ptr_nxt = rd_ptr_r + 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      for (int i = 0; i < arc_pkg::LABEL_DEPTH; i++) begin
        mem_r[i] <= '0;
      end
    end else begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      mem_r <= mem_nxt;
    end
  end

  assign rd_label = mem_r[rd_ptr_r];

  // Only entries below the write pointer count as programmed
  always_comb begin
    cand_hit = 1'b0;
    for (int i = 0; i < arc_pkg::LABEL_DEPTH; i++) begin
      if ((arc_pkg::LABEL_AW+1)'(i) < wr_ptr_r && mem_r[i] == cand_label) begin
        cand_hit = 1'b1;
      end
    end
  end
endmodule // arc_label_mem

//--- rtl/arc_regmap.sv
`timescale 1ns/1ps
module arc_regmap #(
  parameter int CPU_DW = 32
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic cpu_ren_n,
  input wire logic cpu_wen_n,
  input wire logic [8:0] cpu_add,
  input wire logic [CPU_DW-1:0] cpu_din,
  output logic [CPU_DW-1:0] cpu_dout,
  output logic cpu_wait,
  input wire logic [15:0] rx_fifo_empty,
  input wire logic [15:0] rx_fifo_level,
  input wire logic [15:0] rx_fifo_full,
  input wire logic [511:0] rx_fifo_head,
  output logic [15:0] rx_fifo_pop,
  input wire logic [15:0] tx_fifo_empty,
  input wire logic [15:0] tx_fifo_level,
  input wire logic [15:0] tx_fifo_full,
  output logic [15:0] tx_fifo_push,
  output logic [31:0] tx_fifo_wdata,
  input wire logic [15:0] rx_cand_valid,
  input wire logic [511:0] rx_cand_word,
  output logic [15:0] rx_cand_accept,
  output logic [15:0] rx_rate_slow,
  output logic [15:0] rx_parity_en,
  output logic [15:0] rx_parity_even,
  output logic [15:0] tx_rate_slow,
  output logic [15:0] tx_loopback,
  output logic [15:0] tx_parity_en,
  output logic [15:0] tx_parity_even
);
  localparam logic [1:0] LANE_MASK = 2'(CPU_DW / 8 - 1);
  localparam logic [1:0] TOP_LANE = 2'(4 - CPU_DW / 8);

  // ------------------------------------------------------------
  // Address fields
  // ------------------------------------------------------------
  logic [1:0] ridx;

  assign ridx = cpu_add[arc_pkg::IDX_MSB:arc_pkg::IDX_LSB];

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  arc_pkg::arc_state_t st_r, st_nxt;
  logic [2:0] cnt_r, cnt_nxt;
  logic [8:0] add_r, add_nxt;
  logic [CPU_DW-1:0] din_r, din_nxt;
  logic wr_r, wr_nxt;
  logic [CPU_DW-1:0] dout_r, dout_nxt;
  logic [arc_pkg::RX_CTL_W-1:0] rx_ctl_r [arc_pkg::CH_NUM];
  logic [arc_pkg::RX_CTL_W-1:0] rx_ctl_nxt [arc_pkg::CH_NUM];
  logic [arc_pkg::TX_CTL_W-1:0] tx_ctl_r [arc_pkg::CH_NUM];
  logic [arc_pkg::TX_CTL_W-1:0] tx_ctl_nxt [arc_pkg::CH_NUM];
  logic [31:0] tx_stage_r, tx_stage_nxt;
  logic [31:0] tx_wdata_r, tx_wdata_nxt;
  logic [15:0] pop_r, pop_nxt;
  logic [15:0] push_r, push_nxt;
  logic [15:0] lbl_wr_r, lbl_wr_nxt;
  logic [15:0] lbl_rd_r, lbl_rd_nxt;
  logic [15:0] lbl_clr_r, lbl_clr_nxt;
  logic [7:0] lbl_wdata_r, lbl_wdata_nxt;
  logic [7:0] lbl_rd_label [arc_pkg::CH_NUM];
  logic [15:0] lbl_hit;

  // Held request fields
  logic [1:0] h_lane, h_idx;
  logic h_tx, h_lane_ok, h_top;
  logic [3:0] h_ch;
  logic [4:0] h_sh;
  logic [31:0] h_rd_val;
  logic [31:0] h_wmask, h_wval;

  assign h_lane = add_r[arc_pkg::LANE_MSB:arc_pkg::LANE_LSB];
  assign h_idx = add_r[arc_pkg::IDX_MSB:arc_pkg::IDX_LSB];
  assign h_tx = add_r[arc_pkg::DIR_BIT];
  assign h_ch = add_r[arc_pkg::CH_MSB:arc_pkg::CH_LSB];
  assign h_lane_ok = (h_lane & LANE_MASK) == 2'h0;
  assign h_top = h_lane == TOP_LANE;
  assign h_sh = {h_lane, 3'h0};
  assign h_wmask = 32'(({CPU_DW{1'b1}}) << h_sh);
  assign h_wval = 32'(din_r) << h_sh;

  // ------------------------------------------------------------
  // Read mux of the held address
  // ------------------------------------------------------------
  always_comb begin
    h_rd_val = 32'h0000_0000;
    if (!h_tx) begin
      case (h_idx)
        arc_pkg::REG_DATA: h_rd_val = rx_fifo_head[h_ch*32 +: 32];
        arc_pkg::REG_CTRL: h_rd_val = 32'(rx_ctl_r[h_ch]);
        arc_pkg::REG_STAT: begin
          h_rd_val[arc_pkg::ST_EMPTY] = rx_fifo_empty[h_ch];
          h_rd_val[arc_pkg::ST_LEVEL] = rx_fifo_level[h_ch];
          h_rd_val[arc_pkg::ST_FULL] = rx_fifo_full[h_ch];
        end
        arc_pkg::REG_LABEL: h_rd_val = 32'(lbl_rd_label[h_ch]);
        default: h_rd_val = 32'h0000_0000;
      endcase
    end else begin
      case (h_idx)
        arc_pkg::REG_CTRL: h_rd_val = 32'(tx_ctl_r[h_ch]);
        arc_pkg::REG_STAT: begin
          h_rd_val[arc_pkg::ST_EMPTY] = tx_fifo_empty[h_ch];
          h_rd_val[arc_pkg::ST_LEVEL] = tx_fifo_level[h_ch];
          h_rd_val[arc_pkg::ST_FULL] = tx_fifo_full[h_ch];
        end
        default: h_rd_val = 32'h0000_0000;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Access sequencer and register writes
  // ------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    add_nxt = add_r;
    din_nxt = din_r;
    wr_nxt = wr_r;
    dout_nxt = dout_r;
    rx_ctl_nxt = rx_ctl_r;
    tx_ctl_nxt = tx_ctl_r;
    tx_stage_nxt = tx_stage_r;
    tx_wdata_nxt = tx_wdata_r;
    pop_nxt = 16'h0000;
    push_nxt = 16'h0000;
    lbl_wr_nxt = 16'h0000;
    lbl_rd_nxt = 16'h0000;
    lbl_clr_nxt = 16'h0000;
    lbl_wdata_nxt = lbl_wdata_r;
    case (st_r)
      arc_pkg::ARC_IDLE: begin
        if (!cpu_wen_n) begin
          st_nxt = arc_pkg::ARC_BUSY;
          cnt_nxt = arc_pkg::LAT_WR;
          wr_nxt = 1'b1;
          add_nxt = cpu_add;
          din_nxt = cpu_din;
        end else if (!cpu_ren_n) begin
          st_nxt = arc_pkg::ARC_BUSY;
          wr_nxt = 1'b0;
          add_nxt = cpu_add;
          if (ridx == arc_pkg::REG_DATA || ridx == arc_pkg::REG_LABEL) begin
            cnt_nxt = arc_pkg::LAT_DATA_RD;
          end else begin
            cnt_nxt = arc_pkg::LAT_CTRL_RD;
          end
        end
      end
      arc_pkg::ARC_BUSY: begin
        cnt_nxt = cnt_r - 1'b1;
        if (cnt_r == arc_pkg::CNT_ONE) begin
          st_nxt = arc_pkg::ARC_DONE;
          if (!wr_r) begin
            dout_nxt = h_lane_ok ? CPU_DW'(h_rd_val >> h_sh) : '0;
            if (h_lane_ok && !h_tx && h_idx == arc_pkg::REG_DATA && h_top) begin
              pop_nxt[h_ch] = 1'b1;
            end
            if (h_lane_ok && !h_tx && h_idx == arc_pkg::REG_LABEL && h_lane == 2'h0) begin
              lbl_rd_nxt[h_ch] = 1'b1;
            end
          end else if (h_lane_ok) begin
            if (!h_tx) begin
              case (h_idx)
                arc_pkg::REG_CTRL: begin
                  if (h_lane == 2'h0) begin
                    rx_ctl_nxt[h_ch] = din_r[arc_pkg::RX_CTL_W-1:0];
                    lbl_clr_nxt[h_ch] = din_r[arc_pkg::CTL_RELOAD];
                  end
                end
                arc_pkg::REG_LABEL: begin
                  if (h_lane == 2'h0) begin
                    lbl_wdata_nxt = din_r[arc_pkg::LBL_W-1:0];
                    lbl_wr_nxt[h_ch] = 1'b1;
                  end
                end
                default: ;
              endcase
            end else begin
              case (h_idx)
                arc_pkg::REG_DATA: begin
                  tx_stage_nxt = (tx_stage_r & ~h_wmask) | (h_wval & h_wmask);
                  if (h_top) begin
                    tx_wdata_nxt = (tx_stage_r & ~h_wmask) | (h_wval & h_wmask);
                    push_nxt[h_ch] = 1'b1;
                  end
                end
                arc_pkg::REG_CTRL: begin
                  if (h_lane == 2'h0) begin
                    tx_ctl_nxt[h_ch] = din_r[arc_pkg::TX_CTL_W-1:0];
                  end
                end
                default: ;
              endcase
            end
          end
        end
      end
      arc_pkg::ARC_DONE: begin
        if (cpu_ren_n && cpu_wen_n) begin
          st_nxt = arc_pkg::ARC_IDLE;
        end
      end
      default: st_nxt = arc_pkg::ARC_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      st_r <= arc_pkg::ARC_IDLE;
      cnt_r <= 3'h0;
      add_r <= 9'h000;
      din_r <= '0;
      wr_r <= 1'b0;
      dout_r <= '0;
      for (int i = 0; i < arc_pkg::CH_NUM; i++) begin
        rx_ctl_r[i] <= arc_pkg::RX_CTL_RST;
        tx_ctl_r[i] <= arc_pkg::TX_CTL_RST;
      end
      tx_stage_r <= 32'h0000_0000;
      tx_wdata_r <= 32'h0000_0000;
      pop_r <= 16'h0000;
      push_r <= 16'h0000;
      lbl_wr_r <= 16'h0000;
      lbl_rd_r <= 16'h0000;
      lbl_clr_r <= 16'h0000;
      lbl_wdata_r <= 8'h00;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      add_r <= add_nxt;
      din_r <= din_nxt;
      wr_r <= wr_nxt;
      dout_r <= dout_nxt;
      rx_ctl_r <= rx_ctl_nxt;
      tx_ctl_r <= tx_ctl_nxt;
      tx_stage_r <= tx_stage_nxt;
      tx_wdata_r <= tx_wdata_nxt;
      pop_r <= pop_nxt;
      push_r <= push_nxt;
      lbl_wr_r <= lbl_wr_nxt;
      lbl_rd_r <= lbl_rd_nxt;
      lbl_clr_r <= lbl_clr_nxt;
      lbl_wdata_r <= lbl_wdata_nxt;
    end
  end

  // Wait rises combinationally with the sampled strobe
  assign cpu_wait = (st_r == arc_pkg::ARC_BUSY) ||
                    (st_r == arc_pkg::ARC_IDLE && (!cpu_ren_n || !cpu_wen_n));
  assign cpu_dout = dout_r;
  assign rx_fifo_pop = pop_r;
  assign tx_fifo_push = push_r;
  assign tx_fifo_wdata = tx_wdata_r;

  // ------------------------------------------------------------
  // Per-channel label memory, word filter and control outputs
  // ------------------------------------------------------------
  for (genvar g = 0; g < arc_pkg::CH_NUM; g++) begin : g_ch
    logic [31:0] cw;
    logic sdi_ok;
    assign cw = rx_cand_word[g*32 +: 32];

    arc_label_mem u_lbl (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .clear(lbl_clr_r[g]),
      .wr_en(lbl_wr_r[g]),
      .wr_label(lbl_wdata_r),
      .rd_adv(lbl_rd_r[g]),
      .rd_label(lbl_rd_label[g]),
      .cand_label(cw[arc_pkg::LBL_LSB +: arc_pkg::LBL_W]),
      .cand_hit(lbl_hit[g])
    );

    assign sdi_ok = !rx_ctl_r[g][arc_pkg::CTL_SDI_EN] ||
                    (cw[arc_pkg::SDI9_POS] == rx_ctl_r[g][arc_pkg::CTL_SDI9] &&
                     cw[arc_pkg::SDI10_POS] == rx_ctl_r[g][arc_pkg::CTL_SDI10]);
    assign rx_cand_accept[g] = rx_cand_valid[g] && sdi_ok &&
                               (!rx_ctl_r[g][arc_pkg::CTL_FILTER] || lbl_hit[g]);
    assign rx_rate_slow[g] = rx_ctl_r[g][arc_pkg::CTL_RATE];
    assign rx_parity_en[g] = rx_ctl_r[g][arc_pkg::CTL_PAR_EN];
    assign rx_parity_even[g] = rx_ctl_r[g][arc_pkg::CTL_PAR_EVEN];
    assign tx_rate_slow[g] = tx_ctl_r[g][arc_pkg::CTL_RATE];
    assign tx_loopback[g] = tx_ctl_r[g][arc_pkg::CTL_LOOP];
    assign tx_parity_en[g] = tx_ctl_r[g][arc_pkg::CTL_PAR_EN];
    assign tx_parity_even[g] = tx_ctl_r[g][arc_pkg::CTL_PAR_EVEN];
  end
endmodule // arc_regmap

//--- bench/arc_regmap_checker.sv
`timescale 1ns/1ps
module arc_regmap_checker #(
  parameter int CPU_DW = 32
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic cpu_ren_n,
  input wire logic cpu_wen_n,
  input wire logic [8:0] cpu_add,
  input wire logic [CPU_DW-1:0] cpu_din,
  input wire logic [CPU_DW-1:0] cpu_dout,
  input wire logic cpu_wait,
  input wire logic [15:0] rx_fifo_pop,
  input wire logic [15:0] tx_fifo_push,
  input wire logic [31:0] tx_fifo_wdata,
  input wire logic [15:0] rx_cand_valid,
  input wire logic [15:0] rx_cand_accept,
  input wire logic [15:0] rx_rate_slow,
  input wire logic [15:0] rx_parity_en,
  input wire logic [15:0] tx_rate_slow,
  input wire logic [15:0] tx_loopback
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // ----------------------------------------
  // Request decode
  // ----------------------------------------
  logic wait_q;
  always_ff @(posedge sys_clk) wait_q <= cpu_wait;
  wire [1:0] idx = cpu_add[3:2];
  wire [3:0] ch = cpu_add[8:5];
  wire [15:0] ch_oh = 16'h1 << ch;
  wire lane0 = cpu_add[1:0] == 2'h0;
  wire st_r = cpu_wait && !wait_q && cpu_wen_n && !cpu_ren_n;
  wire st_w = cpu_wait && !wait_q && !cpu_wen_n;
  wire ctl = lane0 && (idx == arc_pkg::REG_CTRL || idx == arc_pkg::REG_STAT);
  wire slow = lane0 && !cpu_add[4] && (idx == arc_pkg::REG_DATA || idx == arc_pkg::REG_LABEL);
  wire rxd = lane0 && !cpu_add[4] && idx == arc_pkg::REG_DATA;
  wire txd = lane0 && cpu_add[4] && idx == arc_pkg::REG_DATA;
  wire rxc = lane0 && !cpu_add[4] && idx == arc_pkg::REG_CTRL;
  wire txc = lane0 && cpu_add[4] && idx == arc_pkg::REG_CTRL;
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_ctl_rd; st_r && ctl |-> cpu_wait ##1 cpu_wait ##1 !cpu_wait; endproperty
  a_ctl_rd: assert property (p_ctl_rd) else $error("ctrl read latency wrong");
  property p_slow_rd; st_r && slow |-> cpu_wait [*7] ##1 !cpu_wait; endproperty
  a_slow_rd: assert property (p_slow_rd) else $error("data read latency wrong");
  property p_wr; st_w |-> cpu_wait [*3] ##1 !cpu_wait; endproperty
  a_wr: assert property (p_wr) else $error("write latency wrong");
  property p_pop; st_r && rxd |-> (rx_fifo_pop == 16'h0) [*7] ##1 rx_fifo_pop == ch_oh; endproperty
  a_pop: assert property (p_pop) else $error("pop pulse wrong");
  property p_push;
    st_w && txd |-> ##3 tx_fifo_push == ch_oh && tx_fifo_wdata == $past(cpu_din[31:0], 3);
  endproperty
  a_push: assert property (p_push) else $error("push pulse wrong");
  property p_tx_ctl;
    st_w && txc |-> ##3 tx_rate_slow[ch] == $past(cpu_din[0], 3) &&
      tx_loopback[ch] == $past(cpu_din[1], 3);
  endproperty
  a_tx_ctl: assert property (p_tx_ctl) else $error("tx control output wrong");
  property p_rx_ctl;
    st_w && rxc |-> ##3 rx_rate_slow[ch] == $past(cpu_din[0], 3) &&
      rx_parity_en[ch] == $past(cpu_din[2], 3);
  endproperty
  a_rx_ctl: assert property (p_rx_ctl) else $error("rx control output wrong");
  property p_accept; (rx_cand_accept & ~rx_cand_valid) == 16'h0; endproperty
  a_accept: assert property (p_accept) else $error("accept without word");
  property p_rst;
    disable iff (1'b0) !resetn |=> cpu_dout == '0 && tx_loopback == 16'h0 && rx_rate_slow == 16'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("reset values wrong");
  c_rd: cover property (st_r && rxd);
  c_wr: cover property (st_w && txd);
  c_acc: cover property (rx_cand_accept != 16'h0);
endmodule // arc_regmap_checker

bind arc_regmap arc_regmap_checker #(.CPU_DW(CPU_DW)) u_arc_regmap_checker (
  .sys_clk(sys_clk), .resetn(resetn), .cpu_ren_n(cpu_ren_n), .cpu_wen_n(cpu_wen_n),
  .cpu_add(cpu_add), .cpu_din(cpu_din), .cpu_dout(cpu_dout), .cpu_wait(cpu_wait),
  .rx_fifo_pop(rx_fifo_pop), .tx_fifo_push(tx_fifo_push), .tx_fifo_wdata(tx_fifo_wdata),
  .rx_cand_valid(rx_cand_valid), .rx_cand_accept(rx_cand_accept),
  .rx_rate_slow(rx_rate_slow), .rx_parity_en(rx_parity_en),
  .tx_rate_slow(tx_rate_slow), .tx_loopback(tx_loopback)
);

//--- bench/arc_cpu_model.sv
`timescale 1ns/1ps
module arc_cpu_model (
  input wire logic sys_clk,
  input wire logic cpu_wait,
  input wire logic [31:0] cpu_dout,
  output logic cpu_ren_n,
  output logic cpu_wen_n,
  output logic [8:0] cpu_add,
  output logic [31:0] cpu_din
);
  initial begin
    cpu_ren_n = 1'b1;
    cpu_wen_n = 1'b1;
    cpu_add = 9'h0;
    cpu_din = 32'h0;
  end
  // ----------------------------------------
  // One strobe cycle, held until wait low
  // ----------------------------------------
  task automatic acc(input bit w, input logic [8:0] a, input logic [31:0] d,
                     output logic [31:0] q, output bit t);
    int n;
    @(posedge sys_clk);
    #1;
    cpu_add = a;
    cpu_din = d;
    if (w) cpu_wen_n = 1'b0;
    else cpu_ren_n = 1'b0;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (cpu_wait !== 1'b0 && n < 50);
    @(posedge sys_clk);
    q = cpu_dout;
    t = (n >= 50);
    #1;
    cpu_ren_n = 1'b1;
    cpu_wen_n = 1'b1;
    cpu_add = ~a;
    cpu_din = ~d;
  endtask
endmodule // arc_cpu_model

//--- bench/arc_channel_register_map_test.sv
`timescale 1ns/1ps
module arc_channel_register_map_test;
  logic sys_clk, resetn, cpu_ren_n, cpu_wen_n, cpu_wait;
  logic [8:0] cpu_add;
  logic [31:0] cpu_din, cpu_dout, wdat;
  logic [15:0] rx_e, rx_l, rx_f, tx_e, tx_l, tx_f, cv, pop, push, acc;
  logic [15:0] rrs, rpe, rpv, trs, tlb, tpe, tpv;
  logic [511:0] head, cw;
  logic [7:0] lab[$];
  int err_total, checks_done;
  int rxc[16], txc[16];

  arc_regmap #(.CPU_DW(32)) u_arc_regmap (
    .sys_clk(sys_clk), .resetn(resetn), .cpu_ren_n(cpu_ren_n), .cpu_wen_n(cpu_wen_n),
    .cpu_add(cpu_add), .cpu_din(cpu_din), .cpu_dout(cpu_dout), .cpu_wait(cpu_wait),
    .rx_fifo_empty(rx_e), .rx_fifo_level(rx_l), .rx_fifo_full(rx_f), .rx_fifo_head(head),
    .rx_fifo_pop(pop), .tx_fifo_empty(tx_e), .tx_fifo_level(tx_l), .tx_fifo_full(tx_f),
    .tx_fifo_push(push), .tx_fifo_wdata(wdat), .rx_cand_valid(cv), .rx_cand_word(cw),
    .rx_cand_accept(acc), .rx_rate_slow(rrs), .rx_parity_en(rpe), .rx_parity_even(rpv),
    .tx_rate_slow(trs), .tx_loopback(tlb), .tx_parity_en(tpe), .tx_parity_even(tpv)
  );
  arc_cpu_model u_arc_cpu_model (
    .sys_clk(sys_clk), .cpu_wait(cpu_wait), .cpu_dout(cpu_dout), .cpu_ren_n(cpu_ren_n),
    .cpu_wen_n(cpu_wen_n), .cpu_add(cpu_add), .cpu_din(cpu_din)
  );

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task test_done();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task chk_rd(string n, logic [31:0] e, logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask
  task chk_vec(string n, logic [15:0] e, logic [15:0] g);
    chk_rd(n, {16'h0, e}, {16'h0, g});
  endtask
  function logic [8:0] ad(int c, bit tx, logic [1:0] idx);
    return {c[3:0], tx, idx, 2'h0};
  endfunction
  task bus(bit w, logic [8:0] a, logic [31:0] d, output logic [31:0] q);
    bit t;
    u_arc_cpu_model.acc(w, a, d, q, t);
    if (t) begin
      err_total++;
      $display("mismatch wait exp 0 got 1");
      test_done();
    end
  endtask
  task wr(logic [8:0] a, logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task cand(logic [31:0] w, int ctl);
    bit hit, ok;
    hit = 0;
    foreach (lab[i]) if (lab[i] == w[7:0]) hit = 1;
    ok = !ctl[4] || (w[8] == ctl[5] && w[9] == ctl[6]);
    @(posedge sys_clk);
    #1;
    cv = 16'h4;
    cw[95:64] = w;
    @(negedge sys_clk);
    chk_vec("accept", {13'h0, ok && (!ctl[1] || hit), 2'h0}, acc);
    @(posedge sys_clk);
    #1;
    cv = 16'h0;
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] q;
    int c;
    resetn = 1'b0;
    {rx_e, rx_l, rx_f, tx_e, tx_l, tx_f, cv} = '0;
    head = '0;
    cw = '0;
    err_total = 0;
    checks_done = 0;
    void'($urandom(32'h3ee5));
    repeat (3) @(posedge sys_clk);
    #1 resetn = 1'b1;
    bus(0, ad(5, 0, arc_pkg::REG_CTRL), 0, q);
    chk_rd("rx ctl reset", 32'h0, q);
    bus(0, ad(5, 1, arc_pkg::REG_CTRL), 0, q);
    chk_rd("tx ctl reset", 32'h0, q);
    bus(0, ad(5, 0, arc_pkg::REG_STAT), 0, q);
    chk_rd("rx stat reset", 32'h0, q);
    for (c = 0; c < 16; c++) begin
      rxc[c] = $urandom & 32'h7f;
      txc[c] = $urandom & 32'hf;
      wr(ad(c, 0, arc_pkg::REG_CTRL), rxc[c]);
      wr(ad(c, 1, arc_pkg::REG_CTRL), txc[c]);
    end
    for (c = 0; c < 16; c++) begin
      bus(0, ad(c, 0, arc_pkg::REG_CTRL), 0, q);
      chk_rd("rx ctl", rxc[c], q);
      bus(0, ad(c, 1, arc_pkg::REG_CTRL), 0, q);
      chk_rd("tx ctl", txc[c], q);
      chk_rd("rx rate", rxc[c][0], rrs[c]);
      chk_rd("rx par en", rxc[c][2], rpe[c]);
      chk_rd("rx par even", rxc[c][3], rpv[c]);
      chk_rd("tx rate", txc[c][0], trs[c]);
      chk_rd("tx loop", txc[c][1], tlb[c]);
      chk_rd("tx par en", txc[c][2], tpe[c]);
      chk_rd("tx par even", txc[c][3], tpv[c]);
    end
    repeat (4) begin
      {rx_e, rx_l, rx_f} = 48'({$urandom, $urandom});
      {tx_e, tx_l, tx_f} = 48'({$urandom, $urandom});
      for (c = 0; c < 16; c++) head[c*32+:32] = $urandom;
      c = $urandom % 16;
      bus(0, ad(c, 0, arc_pkg::REG_STAT), 0, q);
      chk_rd("rx stat", {rx_f[c], rx_l[c], rx_e[c]}, q);
      wr(ad(c, 1, arc_pkg::REG_STAT), 32'hffffffff);
      bus(0, ad(c, 1, arc_pkg::REG_STAT), 0, q);
      chk_rd("tx stat", {tx_f[c], tx_l[c], tx_e[c]}, q);
      bus(0, ad(c, 0, arc_pkg::REG_DATA), 0, q);
      chk_rd("rx data", head[c*32+:32], q);
      wr(ad(c, 1, arc_pkg::REG_DATA), $urandom);
      bus(0, ad(c, 1, arc_pkg::REG_LABEL), 0, q);
      chk_rd("tx unused", 32'h0, q);
      bus(0, ad(c, 0, arc_pkg::REG_CTRL) | 9'h1, 0, q);
      chk_rd("unaligned", 32'h0, q);
    end
    wr(ad(2, 0, arc_pkg::REG_CTRL), 32'h80);
    lab = '{8'h11, 8'h5a, 8'ha5};
    foreach (lab[i]) wr(ad(2, 0, arc_pkg::REG_LABEL), lab[i]);
    foreach (lab[i]) begin
      bus(0, ad(2, 0, arc_pkg::REG_LABEL), 0, q);
      chk_rd("label", lab[i], q);
    end
    wr(ad(2, 0, arc_pkg::REG_CTRL), 32'h02);
    cand(($urandom & 32'hfffffc00) | 32'h5a, 32'h02);
    cand(($urandom & 32'hfffffc00) | 32'h3c, 32'h02);
    wr(ad(2, 0, arc_pkg::REG_CTRL), 32'h52);
    cand(32'h15a, 32'h52);
    cand(32'h25a, 32'h52);
    wr(ad(2, 0, arc_pkg::REG_CTRL), 32'h82);
    lab.delete();
    cand(32'h5a, 32'h82);
    test_done();
  end
endmodule // arc_channel_register_map_test
